// file: src/scs_cfg.svh
// Purpose: constants for the smart card serial channel
// Assumes: 32-bit Avalon-MM word registers, word addresses
// Notes: offsets are word addresses, one per register
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// ==========================================================
// register offsets
`define SCS_OFF_MODE 4'h0
`define SCS_OFF_RATE 4'h1
`define SCS_OFF_CTRL 4'h2
`define SCS_OFF_TXD 4'h3
`define SCS_OFF_STAT 4'h4
`define SCS_OFF_RXD 4'h5
`define SCS_OFF_CMODE 4'h6
// ==========================================================
// mode register fields
`define SCS_MODE_HOLD 7
`define SCS_MODE_ODD 4
`define SCS_MODE_RST 8'h00
// control register fields
`define SCS_CTRL_TIE 7
`define SCS_CTRL_RIE 6
`define SCS_CTRL_TE 5
`define SCS_CTRL_RE 4
`define SCS_CTRL_TX_END_IRQ_ENABLE 2
`define SCS_CTRL_CLV 1
`define SCS_CTRL_CKE 0
`define SCS_CTRL_RST 8'h00
// status register fields
`define SCS_ST_TBE 7
`define SCS_ST_RBF 6
`define SCS_ST_OVR 5
`define SCS_ST_ERS 4
`define SCS_ST_PER 3
`define SCS_ST_TDN 2
`define SCS_STAT_RST 8'h84
// card mode register fields
`define SCS_CM_ORDER 3
`define SCS_CM_INV 2
`define SCS_CM_EN 0
`define SCS_CMODE_RST 8'h00
`define SCS_RATE_RST 8'hff
// ==========================================================
// timing: elementary time unit is 372 base clocks
`define SCS_ETU_CLKS 372
`define SCS_SAMPLE_CLK 186
`define SCS_BITS_FRAME 10
`define SCS_ERR_BITS 2
`endif

// file: src/scs_pkg.sv
// Purpose: types for the smart card serial channel
// Assumes: scs_cfg.svh holds the numbers
// Notes: none
package scs_pkg;
  typedef enum logic [2:0] {SCS_IDLE, SCS_TX_BITS, SCS_TX_GUARD, SCS_RX_BITS,
                            SCS_RX_ERR, SCS_RX_GUARD} scs_state_t;
endpackage : scs_pkg

// file: src/scs_baud.sv
// Purpose: base clock tick generator for the card clock and bit timing
// Assumes: rate divides ref_clk into base clock ticks
// Notes: card clock toggles each tick, giving 372 base ticks per bit
`timescale 1ns/10ps
module scs_baud
  import scs_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] rate, // divider value
  input wire logic [1:0] prescale, // prescale select
  output logic tick // one base clock pulse
);
  logic [13:0] cnt_reg;
  // one bit wider than the counter: rate 255 with prescale 3 reaches 16384
  logic [14:0] limit;
  logic [14:0] cnt_inc;
  logic wrap;
  assign limit = ({7'h00, rate} + 15'h0001) << {prescale, 1'b0};
  assign cnt_inc = {1'b0, cnt_reg} + 15'h0001;
  assign wrap = cnt_inc >= limit;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 14'h0000;
      tick <= 1'b0;
    end else begin
      tick <= wrap;
      cnt_reg <= wrap ? 14'h0000 : cnt_inc[13:0];
    end
  end
endmodule : scs_baud

// file: src/scs_sync.sv
// Purpose: two flop synchroniser for a pin input
// Assumes: nothing
// Notes: resets to high, the idle line level
`timescale 1ns/10ps
module scs_sync
  import scs_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic din, // asynchronous input
  output logic dout // synchronised level
);
  logic meta_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : scs_sync

// file: src/scs_top.sv
// Purpose: smart card mode serial channel with Avalon-MM registers
// Assumes: ref_clk 10 MHz, card on half-duplex data line with pull-up
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_top
  import scs_pkg::*;
(
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [2:0] avs_address, // word address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic dma_tx_write, // dma writes next transmit byte
  input wire logic [7:0] dma_tx_data, // dma transmit byte
  input wire logic dma_rx_read, // dma reads receive byte
  input wire logic serial_in_pin, // data line level
  output logic serial_out_pin, // data line drive value
  output logic serial_out_oe, // data line drive enable
  output logic card_clock_pin, // card clock out
  output logic card_clock_oe, // card clock drive enable
  output logic tx_irq, // transmit interrupt
  output logic rx_irq, // receive interrupt
  output logic error_irq, // error interrupt
  output logic tx_end_irq // transmit-end, always low here
);
  // ==========================================================
  // registers and state
  logic [7:0] mode_reg, bit_rate_reg, control_reg, card_mode_reg;
  logic [7:0] tx_data_reg, rx_data_reg, status_reg;
  logic [7:0] status_next;
  scs_state_t state_reg;
  logic [8:0] tick_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [9:0] shift_reg;
  logic par_bad_reg, line_prev_reg, ack_reg, ck_reg;
  logic tick, line_s;
  function automatic logic [7:0] conv(input logic [7:0] d, input logic rev, input logic inv);
    logic [7:0] r;
    r = rev ? {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} : d;
    conv = inv ? ~r : r;
  endfunction : conv
  scs_baud u_baud (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rate(bit_rate_reg),
    .prescale(mode_reg[1:0]),
    .tick(tick)
  );
  scs_sync u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(serial_in_pin),
    .dout(line_s)
  );
  // ==========================================================
  // decode
  // a write lands at the edge where the master sees waitrequest low,
  // which is the second cycle of the access, when ack_reg is up
  wire bus_wr = avs_write && avs_byteenable[0] && ack_reg;
  wire wr_mode = bus_wr && avs_address == `SCS_OFF_MODE;
  wire wr_rate = bus_wr && avs_address == `SCS_OFF_RATE;
  wire wr_ctrl = bus_wr && avs_address == `SCS_OFF_CTRL;
  wire wr_txd = bus_wr && avs_address == `SCS_OFF_TXD;
  wire wr_stat = bus_wr && avs_address == `SCS_OFF_STAT;
  wire wr_cmode = bus_wr && avs_address == `SCS_OFF_CMODE;
  wire en_card = card_mode_reg[`SCS_CM_EN];
  wire tx_en = control_reg[`SCS_CTRL_TE] && en_card;
  wire rx_en = control_reg[`SCS_CTRL_RE] && en_card;
  wire hold = mode_reg[`SCS_MODE_HOLD];
  wire bit_mid = tick && tick_cnt_reg == 9'(`SCS_SAMPLE_CLK - 1);
  wire bit_end = tick && tick_cnt_reg == 9'(`SCS_ETU_CLKS - 1);
  wire tx_load = wr_txd || dma_tx_write;
  wire [7:0] tx_byte = wr_txd ? avs_writedata[7:0] : dma_tx_data;
  wire [7:0] tx_conv = conv(tx_data_reg, card_mode_reg[`SCS_CM_ORDER],
                            card_mode_reg[`SCS_CM_INV]);
  // parity over line levels, odd sense per mode bit
  wire tx_par = ^tx_conv ^ mode_reg[`SCS_MODE_ODD];
  wire start_tx = state_reg == SCS_IDLE && tx_en && !status_reg[`SCS_ST_TBE];
  wire start_rx = state_reg == SCS_IDLE && rx_en && !tx_en && line_prev_reg && !line_s;
  // at the parity sample the data bits sit in [9:2] and the start bit in [1]
  wire rx_par_bad = (^shift_reg[9:2]) ^ mode_reg[`SCS_MODE_ODD] ^ line_s;
  // events
  wire ev_tx_ok, ev_tx_err, ev_rx_ok, ev_rx_par, ev_rx_ovr;
  // done after guard (normal) or right after error window (hold mode)
  wire tx_win = state_reg == SCS_TX_GUARD && bit_cnt_reg == 4'h1 && bit_mid;
  assign ev_tx_err = tx_win && !line_s;
  assign ev_tx_ok = state_reg == SCS_TX_GUARD && bit_end && !par_bad_reg &&
                    (hold ? bit_cnt_reg == 4'h1 : bit_cnt_reg == 4'h2);
  wire rx_last = state_reg == SCS_RX_BITS && bit_cnt_reg == 4'(`SCS_BITS_FRAME - 1) && bit_mid;
  assign ev_rx_par = rx_last && rx_par_bad;
  assign ev_rx_ovr = rx_last && !rx_par_bad && status_reg[`SCS_ST_RBF];
  assign ev_rx_ok = rx_last && !rx_par_bad && !status_reg[`SCS_ST_RBF];
  // ==========================================================
  // status flags: hardware set wins over software clear
  always_comb begin
    status_next = status_reg;
    if (wr_stat) begin
      // software may only clear flags, by writing zero
      status_next = status_reg & (avs_writedata[7:0] | 8'h03);
    end
    if (tx_load) begin
      status_next[`SCS_ST_TBE] = 1'b0;
      status_next[`SCS_ST_TDN] = 1'b0;
    end
    if (dma_tx_write) begin
      status_next[`SCS_ST_TDN] = 1'b0;
    end
    // a software read of rx data leaves the flag; software clears it by a status write
    if (dma_rx_read) begin
      status_next[`SCS_ST_RBF] = 1'b0;
    end
    if (ev_tx_ok) begin
      status_next[`SCS_ST_TDN] = 1'b1;
      status_next[`SCS_ST_TBE] = 1'b1;
    end
    if (ev_tx_err) begin
      status_next[`SCS_ST_ERS] = 1'b1;
    end
    if (ev_rx_ok) begin
      status_next[`SCS_ST_RBF] = 1'b1;
    end
    if (ev_rx_par) begin
      status_next[`SCS_ST_PER] = 1'b1;
    end
    if (ev_rx_ovr) begin
      status_next[`SCS_ST_OVR] = 1'b1;
    end
    status_next[1:0] = 2'b00;
  end
  // ==========================================================
  // bus slave: one wait cycle per access
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      case (avs_address)
        `SCS_OFF_MODE: avs_readdata <= {24'h000000, mode_reg};
        `SCS_OFF_RATE: avs_readdata <= {24'h000000, bit_rate_reg};
        `SCS_OFF_CTRL: avs_readdata <= {24'h000000, control_reg};
        `SCS_OFF_TXD: avs_readdata <= {24'h000000, tx_data_reg};
        `SCS_OFF_STAT: avs_readdata <= {24'h000000, status_reg};
        `SCS_OFF_RXD: avs_readdata <= {24'h000000, rx_data_reg};
        `SCS_OFF_CMODE: avs_readdata <= {24'h000000, card_mode_reg & 8'h0d};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  // ==========================================================
  // software registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= `SCS_MODE_RST;
      bit_rate_reg <= `SCS_RATE_RST;
      control_reg <= `SCS_CTRL_RST;
      card_mode_reg <= `SCS_CMODE_RST;
      tx_data_reg <= 8'h00;
      status_reg <= `SCS_STAT_RST;
    end else begin
      if (wr_mode) mode_reg <= avs_writedata[7:0];
      if (wr_rate) bit_rate_reg <= avs_writedata[7:0];
      if (wr_ctrl) control_reg <= avs_writedata[7:0];
      if (wr_cmode) card_mode_reg <= avs_writedata[7:0];
      if (tx_load) tx_data_reg <= tx_byte;
      status_reg <= status_next;
    end
  end
  // ==========================================================
  // frame engine
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SCS_IDLE;
      tick_cnt_reg <= 9'h000;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 10'h3ff;
      par_bad_reg <= 1'b0;
      line_prev_reg <= 1'b1;
      rx_data_reg <= 8'h00;
    end else begin
      line_prev_reg <= line_s;
      if (tick) tick_cnt_reg <= bit_end ? 9'h000 : tick_cnt_reg + 9'h001;
      case (state_reg)
        SCS_IDLE: begin
          bit_cnt_reg <= 4'h0;
          par_bad_reg <= 1'b0;
          if (start_tx && tick) begin
            shift_reg <= {tx_par, tx_conv, 1'b0};
            // start bit gets a full 372 ticks like every other bit
            tick_cnt_reg <= 9'h000;
            state_reg <= SCS_TX_BITS;
          end else if (start_rx) begin
            tick_cnt_reg <= 9'h000;
            state_reg <= SCS_RX_BITS;
          end
        end
        SCS_TX_BITS: if (!tx_en) state_reg <= SCS_IDLE;
          else if (bit_end) begin
            shift_reg <= {1'b1, shift_reg[9:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(`SCS_BITS_FRAME - 1)) begin
              bit_cnt_reg <= 4'h1;
              state_reg <= SCS_TX_GUARD;
            end
          end
        SCS_TX_GUARD: begin
          if (ev_tx_err) par_bad_reg <= 1'b1;
          if (!tx_en) state_reg <= SCS_IDLE;
          else if (bit_end) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(`SCS_ERR_BITS + 1)) begin
              state_reg <= SCS_IDLE; // resend while buffer still held
            end
          end
        end
        SCS_RX_BITS: if (!rx_en) state_reg <= SCS_IDLE;
          else if (bit_mid) begin
            shift_reg <= {line_s, shift_reg[9:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(`SCS_BITS_FRAME - 1)) begin
              if (!status_reg[`SCS_ST_RBF] || rx_par_bad)
                rx_data_reg <= conv(shift_reg[9:2], card_mode_reg[`SCS_CM_ORDER],
                                    card_mode_reg[`SCS_CM_INV]);
              bit_cnt_reg <= 4'h0;
              state_reg <= rx_par_bad ? SCS_RX_ERR : SCS_RX_GUARD;
            end
          end
        SCS_RX_ERR: if (bit_mid) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(`SCS_ERR_BITS)) state_reg <= SCS_RX_GUARD;
          end
        SCS_RX_GUARD: if (bit_end) state_reg <= SCS_IDLE;
        default: state_reg <= SCS_IDLE;
      endcase
    end
  end
  // on tx success leave the buffer empty so no resend happens
  // ==========================================================
  // pins and interrupts
  wire drive_lo = (state_reg == SCS_TX_BITS && !shift_reg[0]) ||
                  (state_reg == SCS_RX_ERR && bit_cnt_reg != 4'h0);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
      ck_reg <= 1'b0;
      card_clock_pin <= 1'b0;
      card_clock_oe <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      error_irq <= 1'b0;
      tx_end_irq <= 1'b0;
    end else begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= en_card && drive_lo;
      if (tick) ck_reg <= ~ck_reg;
      card_clock_oe <= en_card && (control_reg[`SCS_CTRL_CKE] || hold);
      card_clock_pin <= (hold && !control_reg[`SCS_CTRL_CKE]) ?
                        control_reg[`SCS_CTRL_CLV] : ck_reg;
      tx_irq <= control_reg[`SCS_CTRL_TIE] && status_next[`SCS_ST_TDN];
      rx_irq <= control_reg[`SCS_CTRL_RIE] && status_next[`SCS_ST_RBF];
      error_irq <= control_reg[`SCS_CTRL_RIE] &&
                   |status_next[`SCS_ST_OVR:`SCS_ST_PER];
      tx_end_irq <= 1'b0;
    end
  end
endmodule : scs_top

// file: verification/scs_top_properties.sv
// Purpose: port-level properties of the smart card serial channel
// Assumes: bound to scs_top, one clock domain
// Notes: irq lines are registered, so clears are given three cycles
`timescale 1ns/10ps
module scs_top_properties
  import scs_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic nrst, // reset, active low
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic avs_waitrequest, // stall
  input wire logic [31:0] avs_readdata, // read data
  input wire logic dma_tx_write, // dma transmit write
  input wire logic dma_rx_read, // dma receive read
  input wire logic serial_out_pin, // data drive value
  input wire logic serial_out_oe, // data drive enable
  input wire logic card_clock_oe, // card clock enable
  input wire logic tx_irq, // transmit irq
  input wire logic rx_irq, // receive irq
  input wire logic error_irq, // error irq
  input wire logic tx_end_irq // transmit-end irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // bus and pins
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> s_answer)
    else $error("bus answer not after one wait cycle");
  chk_rd_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_drive_low: assert property (serial_out_oe |-> !serial_out_pin)
    else $error("data line driven high");
  chk_clk_enable: assert property ($changed(card_clock_oe) |->
    $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("clock enable moved without a write");
  // ==========================================================
  // interrupts
  chk_tei_low: assert property (!tx_end_irq)
    else $error("transmit-end irq raised");
  chk_txirq_idle: assert property ($rose(tx_irq) |-> !serial_out_oe)
    else $error("transmit irq while line driven");
  chk_err_no_tx: assert property ($rose(error_irq) |-> !tx_irq)
    else $error("done with card error");
  chk_dma_tx_clr: assert property (dma_tx_write |-> ##[1:3] !tx_irq)
    else $error("dma write left transmit irq");
  chk_dma_rx_clr: assert property (dma_rx_read |-> ##[1:3] !rx_irq)
    else $error("dma read left receive irq");
endmodule : scs_top_properties
bind scs_top scs_top_properties u_scs_top_properties (.ref_clk(ref_clk), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .dma_tx_write(dma_tx_write), .dma_rx_read(dma_rx_read),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .card_clock_oe(card_clock_oe), .tx_irq(tx_irq), .rx_irq(rx_irq),
  .error_irq(error_irq), .tx_end_irq(tx_end_irq));

// file: verification/scs_card_model.sv
// Purpose: behavioural smart card on the half-duplex data line
// Assumes: line has a pull-up; a bit lasts BIT ref_clk cycles
// Notes: err_req counts device frames still to be answered with an error signal
`timescale 1ns/10ps
module scs_card_model
  import scs_pkg::*;
#(
  parameter int BIT = 372
) (
  input wire logic ref_clk, // system clock
  input wire logic line, // resolved line level
  input wire logic dev_oe, // device pulls line low
  output logic drive_low // card pulls line low
);
  int err_req = 0;
  int frames = 0;
  logic sending = 1'b0;
  logic saw_err = 1'b0;
  logic [8:0] raw = 9'h0;
  initial drive_low = 1'b0;
  // ==========================================================
  // frames sent by the device, sampled mid-bit
  always begin : rx_frames
    @(posedge dev_oe);
    if (!sending) begin
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge ref_clk);
        raw[i] = line;
      end
      frames++;
      if (err_req > 0) begin
        err_req--;
        repeat (BIT / 2) @(posedge ref_clk);
        drive_low <= 1'b1;
        repeat (2 * BIT - 4) @(posedge ref_clk);
        drive_low <= 1'b0;
      end
    end
  end
  // ==========================================================
  // frame towards the device; bad flips parity
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {^d ^ bad, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      drive_low <= !f[i];
      repeat (BIT) @(posedge ref_clk);
    end
    drive_low <= 1'b0;
    repeat (BIT + BIT / 2) @(posedge ref_clk);
    saw_err = !line;
    repeat (2 * BIT) @(posedge ref_clk);
    sending = 1'b0;
  endtask : send
endmodule : scs_card_model

// file: verification/tb.sv
// Purpose: self-checking bench for the smart card serial channel
// Assumes: rate 0 and prescale 0, one base tick per ref_clk
// Notes: the card pulls the shared line low through card_low
`timescale 1ns/10ps
module tb
  import scs_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic dma_tx_write = 1'b0, dma_rx_read = 1'b0, card_low;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [7:0] dma_tx_data = 8'h00;
  logic avs_waitrequest, serial_out_pin, serial_out_oe, card_clock_pin, card_clock_oe;
  logic tx_irq, rx_irq, error_irq, tx_end_irq;
  int errors = 0, n_compared = 0;
  wire line = !(serial_out_oe || card_low);
  wire [2:0] irqs = {error_irq, rx_irq, tx_irq};
  always #50 ref_clk = ~ref_clk;
  scs_top u_scs_top (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read),
    .serial_in_pin(line), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .card_clock_pin(card_clock_pin), .card_clock_oe(card_clock_oe), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .error_irq(error_irq), .tx_end_irq(tx_end_irq));
  scs_card_model #(.BIT(372)) u_scs_card_model (.ref_clk(ref_clk), .line(line),
    .dev_oe(serial_out_oe), .drive_low(card_low));
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic timeout();
    errors++;
    tally_and_finish();
  endtask : timeout
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) timeout();
      @(posedge ref_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp(q, exp);
  endtask : rc
  task automatic wait_hi(input int k);
    for (int n = 0; irqs[k] !== 1'b1; n++) begin
      if (n > 30000) timeout();
      @(posedge ref_clk);
    end
  endtask : wait_hi
  task automatic wait_frames(input int m);
    for (int n = 0; u_scs_card_model.frames < m; n++) begin
      if (n > 30000) timeout();
      @(posedge ref_clk);
    end
  endtask : wait_frames
  task automatic setup(input logic [7:0] mode, input logic [7:0] cm, input logic [7:0] en);
    wr(3'h2, 8'h00);
    wr(3'h4, 8'h84);
    wr(3'h0, mode);
    wr(3'h6, cm);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h01);
    repeat (400) @(posedge ref_clk);
    wr(3'h2, en | 8'h01);
  endtask : setup
  task automatic send_tx(input logic [7:0] d);
    wr(3'h3, d);
    wr(3'h4, 8'h7f);
  endtask : send_tx
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rc(3'h4, 32'h84);
    rc(3'h1, 32'hff);
    rc(3'h2, 32'h00);
    wr(3'h7, 8'h5a);
    rc(3'h7, 32'h00);
  endtask : t_regs
  task automatic t_clock();
    setup(8'h28, 8'h01, 8'h00);
    cmp(32'(card_clock_oe), 32'h1);
    wr(3'h0, 8'ha8);
    wr(3'h2, 8'h02);
    repeat (2) @(posedge ref_clk);
    cmp(32'(card_clock_pin), 32'h1);
    wr(3'h2, 8'h00);
    repeat (2) @(posedge ref_clk);
    cmp(32'(card_clock_pin), 32'h0);
  endtask : t_clock
  task automatic t_tx();
    setup(8'h28, 8'h01, 8'he0);
    send_tx(8'hb5);
    wait_frames(1);
    cmp(32'(u_scs_card_model.raw), 32'h1b5);
    repeat (600) @(posedge ref_clk);
    cmp(32'(tx_irq), 32'h0);
    wait_hi(0);
    rc(3'h4, 32'h84);
    u_scs_card_model.err_req = 1;
    send_tx(8'h3c);
    repeat (3) @(posedge ref_clk);
    cmp(32'(tx_irq), 32'h0);
    wait_hi(2);
    cmp(32'(tx_irq), 32'h0);
    wait_frames(3);
    cmp(32'(u_scs_card_model.raw), 32'h03c);
    wait_hi(0);
    rc(3'h4, 32'h94);
    wr(3'h4, 8'hef);
    dma_tx_data <= 8'hc3;
    dma_tx_write <= 1'b1;
    @(posedge ref_clk);
    dma_tx_write <= 1'b0;
    rc(3'h4, 32'h00);
    wait_frames(4);
    cmp(32'(u_scs_card_model.raw), 32'h0c3);
    wait_hi(0);
  endtask : t_tx
  task automatic t_inverse();
    setup(8'hb8, 8'h0d, 8'ha0);
    send_tx(8'h3b);
    wait_frames(5);
    cmp(32'(u_scs_card_model.raw[7:0]), 32'h23);
    repeat (600) @(posedge ref_clk);
    cmp(32'(tx_irq), 32'h1);
    wait_hi(0);
  endtask : t_inverse
  task automatic t_rx();
    setup(8'h28, 8'h01, 8'h50);
    u_scs_card_model.send(8'h96, 1'b0);
    wait_hi(1);
    cmp(32'(tx_irq), 32'h0);
    cmp(32'(u_scs_card_model.saw_err), 32'h0);
    rc(3'h5, 32'h96);
    rc(3'h4, 32'hc4);
    u_scs_card_model.send(8'h0f, 1'b0);
    rc(3'h4, 32'he4);
    cmp(32'(error_irq), 32'h1);
    dma_rx_read <= 1'b1;
    @(posedge ref_clk);
    dma_rx_read <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp(32'(rx_irq), 32'h0);
    wr(3'h4, 8'h84);
    u_scs_card_model.send(8'h71, 1'b1);
    cmp(32'(u_scs_card_model.saw_err), 32'h1);
    rc(3'h4, 32'h8c);
    rc(3'h5, 32'h71);
  endtask : t_rx
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_clock();
    t_tx();
    t_inverse();
    t_rx();
    tally_and_finish();
  end
endmodule : tb
